// >>> pkg/schop_pkg.sv
package schop_pkg;
  localparam int          WORD_W        = 16;
  localparam int          LONG_W        = 32;
  localparam int          FRAME_LEN     = 160;
  localparam int          LAR_CNT       = 8;
  localparam int          SUB_CNT       = 4;
  localparam int          SUB_PARS      = 17;
  localparam int          PAR_CNT       = LAR_CNT + SUB_CNT * SUB_PARS;
  localparam int          FIRST_CHECK   = LAR_CNT + SUB_PARS;
  localparam int          LTP_DEPTH     = 120;
  localparam int          STA_TAPS      = 8;
  localparam int          SYN_TAPS      = 9;
  localparam int          DIV_STEPS     = 15;
  localparam logic [15:0] HOME_LAG      = 16'h0028;
  localparam logic [15:0] ENC_HOME_PCM  = 16'h0008;
  localparam logic [15:0] SAMPLE_MASK   = 16'hFFF8;
  localparam logic [15:0] PARAM_MASK    = 16'h007F;
  localparam logic [15:0] MAX16         = 16'h7FFF;
  localparam logic [15:0] MIN16         = 16'h8000;
  localparam logic [31:0] MAX32         = 32'h7FFFFFFF;
  localparam logic [31:0] MIN32         = 32'h80000000;
  localparam logic [31:0] ROUND_HALF    = 32'h00004000;
  localparam int          FRAC_SHIFT    = 15;
  localparam logic [15:0] HP_LAG [0:PAR_CNT-1] = '{
    16'h0009, 16'h0017, 16'h000F, 16'h0008, 16'h0007, 16'h0003, 16'h0003, 16'h0002,
    16'h0028, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004,
    16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004,
    16'h0028, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004,
    16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004,
    16'h0028, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004,
    16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004,
    16'h0028, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0003,
    16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004};
  typedef enum logic [3:0] {
    SCHOP_ADD, SCHOP_SUB, SCHOP_MULT, SCHOP_MULT_R, SCHOP_ABS, SCHOP_DIV,
    SCHOP_L_MULT, SCHOP_L_ADD, SCHOP_L_SUB, SCHOP_SHL, SCHOP_SHR, SCHOP_DEPOSIT, SCHOP_EXTRACT
  } schop_op_t;
endpackage : schop_pkg

// >>> pkg/schop_alu_if.sv
`timescale 1ns/1ps
interface schop_alu_if;
  import schop_pkg::*;
  schop_op_t   op;
  logic        start;
  logic [15:0] a16;
  logic [15:0] b16;
  logic [31:0] a32;
  logic [31:0] b32;
  logic [15:0] res16;
  logic [31:0] res32;
  logic        done;
  modport master (output op, start, a16, b16, a32, b32, input res16, res32, done);
  modport slave  (input op, start, a16, b16, a32, b32, output res16, res32, done);
endinterface : schop_alu_if

// >>> src/schop_alu.sv
`timescale 1ns/1ps
module schop_alu (
  input  wire logic  i_clk,
  input  wire logic  i_reset_n,
  schop_alu_if.slave alu
);
  import schop_pkg::*;
  logic signed [31:0] prod;
  logic signed [32:0] sum33;
  logic signed [16:0] sum17;
  logic        [15:0] r16;
  logic        [31:0] r32;
  logic        [31:0] div_num_reg;
  logic        [15:0] div_q_reg;
  logic        [4:0]  div_cnt_reg;
  logic               div_busy_reg;
  logic               div_end_reg;
  logic        [31:0] div_den_reg;
  logic signed [5:0]  sh;
  logic               both_min;
  always_comb begin
    prod     = $signed(alu.a16) * $signed(alu.b16);
    both_min = (alu.a16 == MIN16) && (alu.b16 == MIN16);
    sh       = $signed(alu.b16[5:0]);
    sum17    = 17'sd0;
    sum33    = 33'sd0;
    r16      = 16'h0000;
    r32      = 32'h00000000;
    unique case (alu.op)
      SCHOP_ADD, SCHOP_SUB: begin
        sum17 = (alu.op == SCHOP_ADD) ? ($signed({alu.a16[15], alu.a16}) + $signed({alu.b16[15], alu.b16}))
                                      : ($signed({alu.a16[15], alu.a16}) - $signed({alu.b16[15], alu.b16}));
        r16 = (sum17[16] == sum17[15]) ? sum17[15:0] : (sum17[16] ? MIN16 : MAX16);
      end
      SCHOP_MULT: r16 = both_min ? MAX16 : prod[30:15];
      SCHOP_MULT_R: begin
        r32 = 32'(prod + $signed(ROUND_HALF));
        r16 = both_min ? MAX16 : r32[30:15];
      end
      SCHOP_ABS: r16 = (alu.a16 == MIN16) ? MAX16 : (alu.a16[15] ? 16'(-alu.a16) : alu.a16);
      SCHOP_DIV: r16 = div_q_reg;
      SCHOP_L_MULT: r32 = {prod[30:0], 1'b0};
      SCHOP_L_ADD, SCHOP_L_SUB: begin
        sum33 = (alu.op == SCHOP_L_ADD) ? ($signed({alu.a32[31], alu.a32}) + $signed({alu.b32[31], alu.b32}))
                                        : ($signed({alu.a32[31], alu.a32}) - $signed({alu.b32[31], alu.b32}));
        r32 = (sum33[32] == sum33[31]) ? sum33[31:0] : (sum33[32] ? MIN32 : MAX32);
      end
      SCHOP_SHL: begin
        r16 = sh[5] ? 16'($signed(alu.a16) >>> (-sh)) : 16'(alu.a16 << sh);
        r32 = sh[5] ? 32'($signed(alu.a32) >>> (-sh)) : 32'(alu.a32 << sh);
      end
      SCHOP_SHR: begin
        r16 = sh[5] ? 16'(alu.a16 << (-sh)) : 16'($signed(alu.a16) >>> sh);
        r32 = sh[5] ? 32'(alu.a32 << (-sh)) : 32'($signed(alu.a32) >>> sh);
      end
      SCHOP_DEPOSIT: r32 = {{16{alu.a16[15]}}, alu.a16};
      SCHOP_EXTRACT: r16 = alu.a32[15:0];
    endcase
  end
  // restoring division, one quotient bit per clock
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_busy_reg <= 1'b0;
      div_cnt_reg  <= 5'h00;
      div_num_reg  <= 32'h00000000;
      div_den_reg  <= 32'h00000000;
      div_q_reg    <= 16'h0000;
    end else if (alu.start && alu.op == SCHOP_DIV && !div_busy_reg) begin
      div_busy_reg <= (alu.a16 != alu.b16);
      div_cnt_reg  <= 5'h00;
      div_num_reg  <= {16'h0000, alu.a16};
      div_den_reg  <= {16'h0000, alu.b16};
      div_q_reg    <= (alu.a16 == alu.b16) ? MAX16 : 16'h0000;
    end else if (div_busy_reg) begin
      if ({div_num_reg[30:0], 1'b0} >= div_den_reg) begin
        div_num_reg <= {div_num_reg[30:0], 1'b0} - div_den_reg;
        div_q_reg   <= {div_q_reg[14:0], 1'b1};
      end else begin
        div_num_reg <= {div_num_reg[30:0], 1'b0};
        div_q_reg   <= {div_q_reg[14:0], 1'b0};
      end
      div_cnt_reg  <= div_cnt_reg + 5'h01;
      div_busy_reg <= (div_cnt_reg != 5'(DIV_STEPS - 1));
    end
  end
  // done trails the last quotient bit by a clock so the result register sees the finished quotient
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_end_reg <= 1'b0;
    end else begin
      div_end_reg <= (div_busy_reg && div_cnt_reg == 5'(DIV_STEPS - 1))
                     || (alu.start && alu.op == SCHOP_DIV && alu.a16 == alu.b16 && !div_busy_reg);
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      alu.res16 <= 16'h0000;
      alu.res32 <= 32'h00000000;
      alu.done  <= 1'b0;
    end else begin
      alu.res16 <= r16;
      alu.res32 <= r32;
      alu.done  <= (alu.start && alu.op != SCHOP_DIV) || div_end_reg;
    end
  end
  AST_ABS_MIN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    alu.start && alu.op == SCHOP_ABS && alu.a16 == MIN16 |=> alu.res16 == MAX16)
    else $error("abs of minimum not saturated");
  AST_ADD_SAT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    alu.start && alu.op == SCHOP_ADD && alu.a16 == MAX16 && !alu.b16[15] |=> alu.res16 == MAX16)
    else $error("add overflow not clamped");
  AST_MULT_MIN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    alu.start && alu.op == SCHOP_MULT && alu.a16 == MIN16 && alu.b16 == MIN16 |=> alu.res16 == MAX16)
    else $error("mult of two minima not clamped");
  AST_DEPOSIT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    alu.start && alu.op == SCHOP_DEPOSIT |=> alu.res32[31:16] == {16{$past(alu.a16[15])}})
    else $error("deposit lost sign extension");
  AST_DIV_TIME: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    alu.start && alu.op == SCHOP_DIV && !div_busy_reg && alu.a16 != alu.b16 |-> ##[16:17] alu.done)
    else $error("divide did not finish in time");
endmodule : schop_alu

// >>> src/schop_decoder_homing.sv
`timescale 1ns/1ps
// Function
// - replace output by encoder homing frame when home
// - home every sub-module after homing frame
// - in home state check LARs, subframe one
// - encoder home clears offset, tilt, LAR, delay
// - encoder homing also resets voice activity state
// - decoder home: lag 40, clear memories
// - datapath words are 16 or 32 bits
// - use only valid sample and parameter bits
// - left shift zero fills, negative shifts right
// - right shift sign extends, negative shifts left
// - 16-bit add saturates
// - 16-bit subtract saturates
// - frac multiply shifts by 15, clamps minima
// - rounded multiply adds 16384 first
// - abs of minimum gives 32767
// - fractional divide truncates, equal gives 32767
// - long product is doubled product
// - 32-bit add saturates
// - 32-bit subtract saturates
// - 16 to 32 sign-extends
// - 32 to 16 keeps low half
// - constants sign-extended before 32-bit use
// - encoder homing frame: 160 samples of 0008
// - homing detection compares every parameter outside home state; in home state, LARs, subframe one and the last word
module schop_decoder_homing (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_par_valid,
  input  wire logic [15:0]       i_par_data,
  input  wire logic              i_par_last,
  input  wire logic              i_bad_frame,
  input  wire logic              i_enc_frame_done,
  input  wire logic              i_enc_homing_frame,
  input  wire logic              i_pcm_valid,
  input  wire logic [15:0]       i_pcm_data,
  input  wire logic              i_pcm_last,
  input  wire schop_pkg::schop_op_t i_alu_op,
  input  wire logic              i_alu_start,
  input  wire logic [15:0]       i_alu_a16,
  input  wire logic [15:0]       i_alu_b16,
  input  wire logic [31:0]       i_alu_a32,
  input  wire logic [31:0]       i_alu_b32,
  output logic                   o_alu_done,
  output logic [15:0]            o_alu_res16,
  output logic [31:0]            o_alu_res32,
  output logic                   o_pcm_valid,
  output logic [15:0]            o_pcm_data,
  output logic                   o_pcm_last,
  output logic                   o_dec_home_pulse,
  output logic                   o_dec_in_home,
  output logic                   o_enc_home_pulse,
  output logic [15:0]            o_dec_prev_lag,
  output logic                   o_homing_detect
);
  import schop_pkg::*;
  // pins from the frame source arrive asynchronously: two stages each
  logic        pv_s1_reg, pv_s2_reg, pl_s1_reg, pl_s2_reg, bf_s1_reg, bf_s2_reg;
  logic [15:0] pd_s1_reg, pd_s2_reg;
  logic        sv_s1_reg, sv_s2_reg, sl_s1_reg, sl_s2_reg;
  logic [15:0] sd_s1_reg, sd_s2_reg;
  logic        ed_s1_reg, ed_s2_reg, eh_s1_reg, eh_s2_reg;
  logic [6:0]  par_idx_reg;
  logic        match_reg, match_first_reg, bad_reg, home_reg, replace_reg, home_pend_reg;
  logic [15:0] par_valid_bits;
  logic        par_hit;
  logic [15:0] dec_ltp_delay_line [0:LTP_DEPTH-1];
  logic [15:0] rx_prev_area_ratios [0:LAR_CNT-1];
  logic [15:0] synthesis_lattice_memory [0:SYN_TAPS-1];
  logic [15:0] deemphasis_filter_state;
  logic [15:0] offset_fir_state;
  logic [31:0] offset_iir_accum;
  logic [15:0] tilt_filter_last_input;
  logic [15:0] prev_decoded_area_ratios [0:LAR_CNT-1];
  logic [15:0] analysis_lattice_memory [0:STA_TAPS-1];
  logic [15:0] ltp_delay_line [0:LTP_DEPTH-1];
  logic        voice_act_state_reg;
  logic        cng_state_reg;
  schop_alu_if alu_bus ();
  assign alu_bus.op    = i_alu_op;
  assign alu_bus.start = i_alu_start;
  assign alu_bus.a16   = i_alu_a16;
  assign alu_bus.b16   = i_alu_b16;
  assign alu_bus.a32   = i_alu_a32;
  assign alu_bus.b32   = i_alu_b32;
  schop_alu u_alu (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .alu       (alu_bus.slave)
  );
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_alu_done  <= 1'b0;
      o_alu_res16 <= 16'h0000;
      o_alu_res32 <= 32'h00000000;
    end else begin
      o_alu_done  <= alu_bus.done;
      o_alu_res16 <= alu_bus.res16;
      o_alu_res32 <= alu_bus.res32;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {pv_s1_reg, pv_s2_reg, pl_s1_reg, pl_s2_reg, bf_s1_reg, bf_s2_reg} <= 6'h00;
      {sv_s1_reg, sv_s2_reg, sl_s1_reg, sl_s2_reg} <= 4'h0;
      {ed_s1_reg, ed_s2_reg, eh_s1_reg, eh_s2_reg} <= 4'h0;
      pd_s1_reg <= 16'h0000;
      pd_s2_reg <= 16'h0000;
      sd_s1_reg <= 16'h0000;
      sd_s2_reg <= 16'h0000;
    end else begin
      pv_s1_reg <= i_par_valid;
      pv_s2_reg <= pv_s1_reg;
      pl_s1_reg <= i_par_last;
      pl_s2_reg <= pl_s1_reg;
      bf_s1_reg <= i_bad_frame;
      bf_s2_reg <= bf_s1_reg;
      pd_s1_reg <= i_par_data;
      pd_s2_reg <= pd_s1_reg;
      sv_s1_reg <= i_pcm_valid;
      sv_s2_reg <= sv_s1_reg;
      sl_s1_reg <= i_pcm_last;
      sl_s2_reg <= sl_s1_reg;
      sd_s1_reg <= i_pcm_data;
      sd_s2_reg <= sd_s1_reg;
      ed_s1_reg <= i_enc_frame_done;
      ed_s2_reg <= ed_s1_reg;
      eh_s1_reg <= i_enc_homing_frame;
      eh_s2_reg <= eh_s1_reg;
    end
  end
  always_comb begin
    par_valid_bits = pd_s2_reg & PARAM_MASK;
    par_hit        = (par_idx_reg < 7'(PAR_CNT)) && (par_valid_bits == HP_LAG[par_idx_reg]);
  end
  // the frame is judged while it streams; only the verdict waits for the frame end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      par_idx_reg     <= 7'h00;
      match_reg       <= 1'b1;
      match_first_reg <= 1'b1;
      bad_reg         <= 1'b0;
    end else if (pv_s2_reg) begin
      if (pl_s2_reg) begin
        par_idx_reg     <= 7'h00;
        match_reg       <= 1'b1;
        match_first_reg <= 1'b1;
        bad_reg         <= 1'b0;
      end else begin
        par_idx_reg     <= par_idx_reg + 7'h01;
        match_reg       <= match_reg & par_hit;
        match_first_reg <= match_first_reg & (par_hit | (par_idx_reg >= 7'(FIRST_CHECK)));
        bad_reg         <= bad_reg | bf_s2_reg;
      end
    end
  end
  logic frame_is_homing;
  always_comb begin
    // in home state the short check suffices; a shorter frame than PAR_CNT never matches
    frame_is_homing = !(bad_reg | bf_s2_reg) && par_hit && (par_idx_reg == 7'(PAR_CNT - 1))
                      && (home_reg ? match_first_reg : match_reg);
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_homing_detect <= 1'b0;
      replace_reg     <= 1'b0;
      home_pend_reg   <= 1'b0;
    end else begin
      o_homing_detect <= pv_s2_reg && pl_s2_reg && frame_is_homing;
      if (pv_s2_reg && pl_s2_reg) begin
        replace_reg   <= frame_is_homing && home_reg;
        home_pend_reg <= frame_is_homing;
      end else if (sv_s2_reg && sl_s2_reg) begin
        replace_reg   <= 1'b0;
        home_pend_reg <= 1'b0;
      end
    end
  end
  // output frame: decoded normally, overwritten only when the decoder started home
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pcm_valid <= 1'b0;
      o_pcm_data  <= 16'h0000;
      o_pcm_last  <= 1'b0;
    end else begin
      o_pcm_valid <= sv_s2_reg;
      o_pcm_last  <= sv_s2_reg & sl_s2_reg;
      o_pcm_data  <= replace_reg ? ENC_HOME_PCM : (sd_s2_reg & SAMPLE_MASK);
    end
  end
  logic dec_home_now;
  assign dec_home_now = home_pend_reg && sv_s2_reg && sl_s2_reg;
  // home state is left when a non-homing frame starts decoding
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      home_reg         <= 1'b1;
      o_dec_home_pulse <= 1'b0;
      o_dec_in_home    <= 1'b1;
    end else begin
      o_dec_home_pulse <= dec_home_now;
      if (dec_home_now) begin
        home_reg <= 1'b1;
      end else if (pv_s2_reg && pl_s2_reg && !frame_is_homing) begin
        home_reg <= 1'b0;
      end
      o_dec_in_home <= home_reg;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dec_prev_lag          <= HOME_LAG;
      deemphasis_filter_state <= 16'h0000;
      cng_state_reg           <= 1'b0;
      for (int i = 0; i < LTP_DEPTH; i++) dec_ltp_delay_line[i] <= 16'h0000;
      for (int i = 0; i < LAR_CNT; i++) rx_prev_area_ratios[i] <= 16'h0000;
      for (int i = 0; i < SYN_TAPS; i++) synthesis_lattice_memory[i] <= 16'h0000;
    end else if (dec_home_now) begin
      o_dec_prev_lag          <= HOME_LAG;
      deemphasis_filter_state <= 16'h0000;
      cng_state_reg           <= 1'b0;
      for (int i = 0; i < LTP_DEPTH; i++) dec_ltp_delay_line[i] <= 16'h0000;
      for (int i = 0; i < LAR_CNT; i++) rx_prev_area_ratios[i] <= 16'h0000;
      for (int i = 0; i < SYN_TAPS; i++) synthesis_lattice_memory[i] <= 16'h0000;
    end else begin
      if (sv_s2_reg) begin
        deemphasis_filter_state <= sd_s2_reg & SAMPLE_MASK;
        cng_state_reg           <= 1'b1;
      end
      // last subframe lag is kept; a homing reset overrides it at the frame end
      if (pv_s2_reg && par_idx_reg == 7'(PAR_CNT - SUB_PARS)) begin
        o_dec_prev_lag <= par_valid_bits;
      end
    end
  end
  logic enc_home_now;
  assign enc_home_now = ed_s2_reg && eh_s2_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_enc_home_pulse       <= 1'b0;
      offset_fir_state       <= 16'h0000;
      offset_iir_accum       <= 32'h00000000;
      tilt_filter_last_input <= 16'h0000;
      voice_act_state_reg    <= 1'b0;
      for (int i = 0; i < LAR_CNT; i++) prev_decoded_area_ratios[i] <= 16'h0000;
      for (int i = 0; i < STA_TAPS; i++) analysis_lattice_memory[i] <= 16'h0000;
      for (int i = 0; i < LTP_DEPTH; i++) ltp_delay_line[i] <= 16'h0000;
    end else begin
      o_enc_home_pulse <= enc_home_now;
      if (enc_home_now) begin
        offset_fir_state       <= 16'h0000;
        offset_iir_accum       <= 32'h00000000;
        tilt_filter_last_input <= 16'h0000;
        voice_act_state_reg    <= 1'b0;
        for (int i = 0; i < LAR_CNT; i++) prev_decoded_area_ratios[i] <= 16'h0000;
        for (int i = 0; i < STA_TAPS; i++) analysis_lattice_memory[i] <= 16'h0000;
        for (int i = 0; i < LTP_DEPTH; i++) ltp_delay_line[i] <= 16'h0000;
      end else if (ed_s2_reg) begin
        voice_act_state_reg <= 1'b1;
      end
    end
  end
  // the frame verdict is taken on the last parameter word only
  sequence s_param_frame_end;
    pv_s2_reg && pl_s2_reg;
  endsequence : s_param_frame_end
  sequence s_home_entry;
    o_dec_home_pulse ##1 o_dec_in_home;
  endsequence : s_home_entry
  AST_REPLACE_OUT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    replace_reg && sv_s2_reg |=> o_pcm_valid && o_pcm_data == ENC_HOME_PCM)
    else $error("homing output not replaced");
  AST_HOME_AFTER: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    dec_home_now |=> s_home_entry)
    else $error("home state not entered after homing frame");
  AST_LAG_HOME: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    dec_home_now |=> o_dec_prev_lag == HOME_LAG)
    else $error("previous lag not homed");
  AST_SAMPLE_MASK: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    sv_s2_reg |=> o_pcm_data[2:0] == 3'h0)
    else $error("invalid sample bits leaked");
  AST_BOUNDARY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_dec_home_pulse |-> $past(sv_s2_reg) && $past(sl_s2_reg))
    else $error("homing applied mid frame");
  AST_NO_BAD_HOME: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    pv_s2_reg && pl_s2_reg && (bad_reg || bf_s2_reg) |=> !home_pend_reg)
    else $error("bad frame triggered homing");
  AST_ENC_HOME: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    enc_home_now |=> offset_iir_accum == 32'h00000000 && o_enc_home_pulse)
    else $error("encoder state not homed");
  AST_DETECT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_param_frame_end ##0 frame_is_homing |=> o_homing_detect)
    else $error("homing frame not reported");
  AST_REPLACE_HOME_ONLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_param_frame_end ##0 !home_reg |=> !replace_reg)
    else $error("output replaced outside home state");
  AST_ENC_PLAIN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ed_s2_reg && !eh_s2_reg |=> !o_enc_home_pulse)
    else $error("encoder homed on a plain frame");
  AST_PCM_LAST: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    sv_s2_reg && sl_s2_reg |=> o_pcm_valid && o_pcm_last)
    else $error("frame end marker lost");
endmodule : schop_decoder_homing

// >>> bench/schop_far_end.sv
`timescale 1ns/1ps
module schop_far_end (
  input  wire logic        i_clk,
  output logic             o_par_valid,
  output logic [15:0]      o_par_data,
  output logic             o_par_last,
  output logic             o_pcm_valid,
  output logic [15:0]      o_pcm_data,
  output logic             o_pcm_last
);
  import schop_pkg::*;
  initial begin
    o_par_valid = 1'b0;
    o_par_data  = 16'h0000;
    o_par_last  = 1'b0;
    o_pcm_valid = 1'b0;
    o_pcm_data  = 16'h0000;
    o_pcm_last  = 1'b0;
  end
  // flip_at picks one word to spoil, -1 sends a clean homing frame
  task automatic send_par(input int flip_at);
    for (int k = 0; k < PAR_CNT; k++) begin
      @(posedge i_clk);
      o_par_valid <= 1'b1;
      o_par_data  <= (HP_LAG[k] ^ ((k == flip_at) ? 16'h0001 : 16'h0000)) | 16'hFF80;
      o_par_last  <= (k == PAR_CNT - 1);
      @(posedge i_clk);
      o_par_valid <= 1'b0;
      // word held long enough for the pin synchroniser to catch it
      repeat (3) @(posedge i_clk);
    end
    o_par_data <= ~o_par_data;
    o_par_last <= 1'b0;
  endtask : send_par
  task automatic send_pcm();
    for (int k = 0; k < FRAME_LEN; k++) begin
      @(posedge i_clk);
      o_pcm_valid <= 1'b1;
      o_pcm_data  <= 16'(k * 16'h0133 + 16'h0005);
      o_pcm_last  <= (k == FRAME_LEN - 1);
    end
    @(posedge i_clk);
    o_pcm_valid <= 1'b0;
    o_pcm_last  <= 1'b0;
    o_pcm_data  <= ~o_pcm_data;
  endtask : send_pcm
endmodule : schop_far_end

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import schop_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        bad_frame = 1'b0;
  logic        enc_done = 1'b0;
  logic        enc_home = 1'b0;
  schop_op_t   alu_op = SCHOP_ADD;
  logic        alu_start = 1'b0;
  logic [15:0] a16 = 16'h0000, b16 = 16'h0000, r16, q_data, prev_lag, par_data, pcm_data;
  logic [31:0] a32 = 32'h0, b32 = 32'h0, r32;
  logic        par_valid, par_last, pcm_valid, pcm_last, alu_done, q_valid, home_pulse, in_home, enc_pulse, detect;
  logic        repl = 1'b0;
  logic        q_last;
  int          n_errors = 0, total_checks = 0, cycles = 0, seen = 0, n_det = 0, n_home = 0, n_enc = 0;
  always #25 clk = ~clk;
  schop_decoder_homing uut (.i_clk(clk), .i_reset_n(reset_n), .i_par_valid(par_valid), .i_par_data(par_data),
    .i_par_last(par_last), .i_bad_frame(bad_frame), .i_enc_frame_done(enc_done), .i_enc_homing_frame(enc_home),
    .i_pcm_valid(pcm_valid), .i_pcm_data(pcm_data), .i_pcm_last(pcm_last), .i_alu_op(alu_op),
    .i_alu_start(alu_start), .i_alu_a16(a16), .i_alu_b16(b16), .i_alu_a32(a32), .i_alu_b32(b32),
    .o_alu_done(alu_done), .o_alu_res16(r16), .o_alu_res32(r32), .o_pcm_valid(q_valid), .o_pcm_data(q_data),
    .o_pcm_last(q_last), .o_dec_home_pulse(home_pulse), .o_dec_in_home(in_home), .o_enc_home_pulse(enc_pulse),
    .o_dec_prev_lag(prev_lag), .o_homing_detect(detect));
  schop_far_end p (.i_clk(clk), .o_par_valid(par_valid), .o_par_data(par_data), .o_par_last(par_last),
    .o_pcm_valid(pcm_valid), .o_pcm_data(pcm_data), .o_pcm_last(pcm_last));
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // counts pulses seen; a hang ends the run
  always @(posedge clk) begin
    cycles++;
    n_det += int'(detect === 1'b1);
    n_home += int'(home_pulse === 1'b1);
    n_enc += int'(enc_pulse === 1'b1);
    if (q_valid === 1'b1) begin
      check("pcm_out", q_data, repl ? ENC_HOME_PCM : (16'(seen * 16'h0133 + 16'h0005) & SAMPLE_MASK));
      check("pcm_last", q_last, 32'(seen == FRAME_LEN - 1));
      seen++;
    end
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic alu(input schop_op_t op, input logic [31:0] a, b, exp, input logic wide);
    alu_op <= op;
    a16 <= a[15:0];
    b16 <= b[15:0];
    a32 <= a;
    b32 <= b;
    alu_start <= 1'b1;
    @(posedge clk);
    alu_start <= 1'b0;
    for (int i = 0; i < 30 && alu_done !== 1'b1; i++) @(posedge clk);
    check("alu_result", wide ? r32 : {16'h0000, r16}, exp);
  endtask : alu
  task automatic alu_ops();
    alu(SCHOP_ADD, 32'h7FFF, 32'h1, 32'h7FFF, 0);
    alu(SCHOP_ADD, 32'h8000, 32'hFFFF, 32'h8000, 0);
    alu(SCHOP_SUB, 32'h8000, 32'h1, 32'h8000, 0);
    alu(SCHOP_SUB, 32'h7FFF, 32'hFFFF, 32'h7FFF, 0);
    alu(SCHOP_MULT, 32'h8000, 32'h8000, 32'h7FFF, 0);
    alu(SCHOP_MULT, 32'h4000, 32'h4000, 32'h2000, 0);
    alu(SCHOP_MULT_R, 32'h8000, 32'h8000, 32'h7FFF, 0);
    alu(SCHOP_MULT_R, 32'h1, 32'h4000, 32'h1, 0);
    alu(SCHOP_ABS, 32'h8000, 32'h0, 32'h7FFF, 0);
    alu(SCHOP_DIV, 32'h1, 32'h3, 32'h2AAA, 0);
    alu(SCHOP_DIV, 32'h3, 32'h3, 32'h7FFF, 0);
    alu(SCHOP_L_MULT, 32'hFFFF, 32'h1, 32'hFFFFFFFE, 1);
    alu(SCHOP_L_ADD, 32'h7FFFFFFF, 32'h1, 32'h7FFFFFFF, 1);
    alu(SCHOP_L_ADD, 32'h80000000, 32'hFFFFFFFF, 32'h80000000, 1);
    alu(SCHOP_L_SUB, 32'h80000000, 32'h1, 32'h80000000, 1);
    alu(SCHOP_L_SUB, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF, 1);
    alu(SCHOP_SHL, 32'h80008000, 32'h1, 32'h0, 0);
    alu(SCHOP_SHL, 32'h80008000, 32'h1, 32'h10000, 1);
    alu(SCHOP_SHL, 32'h80008000, 32'h3F, 32'hC0004000, 1);
    alu(SCHOP_SHR, 32'h80008000, 32'h1, 32'hC000, 0);
    alu(SCHOP_SHR, 32'h80008000, 32'h3E, 32'h20000, 1);
    alu(SCHOP_DEPOSIT, 32'h8001, 32'h0, 32'hFFFF8001, 1);
    alu(SCHOP_EXTRACT, 32'h12348765, 32'h0, 32'h8765, 0);
  endtask : alu_ops
  task automatic enc_homing();
    for (int h = 0; h < 2; h++) begin
      n_enc = 0;
      enc_home <= h[0];
      enc_done <= 1'b1;
      @(posedge clk);
      enc_done <= 1'b0;
      repeat (6) @(posedge clk);
      check("enc_home_pulse", n_enc, h);
    end
  endtask : enc_homing
  // exp_home below zero skips the home flag, its value after a bad frame is left open
  task automatic par_frame(input int flip, input logic bad, input int exp_det, input int exp_home);
    n_det = 0;
    bad_frame <= bad;
    p.send_par(flip);
    repeat (6) @(posedge clk);
    bad_frame <= 1'b0;
    check("homing_detect", n_det, exp_det);
    if (exp_home >= 0) check("in_home", in_home, exp_home);
    check("prev_lag", prev_lag, HP_LAG[PAR_CNT - SUB_PARS] ^ 16'(flip == PAR_CNT - SUB_PARS));
  endtask : par_frame
  task automatic pcm_frame(input logic rep, input int exp_pulse);
    repl = rep;
    seen = 0;
    n_home = 0;
    p.send_pcm();
    repeat (8) @(posedge clk);
    check("pcm_count", seen, FRAME_LEN);
    check("home_pulse", n_home, exp_pulse);
    if (exp_pulse > 0) check("prev_lag", prev_lag, HOME_LAG);
  endtask : pcm_frame
  task automatic decoder_homing();
    par_frame(45, 0, 1, 1);
    pcm_frame(1, 1);
    par_frame(-1, 1, 0, -1);
    pcm_frame(0, 0);
    par_frame(0, 0, 0, 0);
    pcm_frame(0, 0);
    par_frame(45, 0, 0, 0);
    pcm_frame(0, 0);
    par_frame(PAR_CNT - SUB_PARS, 0, 0, 0);
    par_frame(-1, 0, 1, 0);
    pcm_frame(0, 1);
    par_frame(-1, 0, 1, 1);
    pcm_frame(1, 1);
  endtask : decoder_homing
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("in_home", in_home, 32'h1);
    check("prev_lag", prev_lag, HOME_LAG);
    alu_ops();
    enc_homing();
    decoder_homing();
    tally_and_finish();
  end
endmodule : testbench
